/* test/dram_link_assertions.sv */
`include "dram_link_consts.svh"

module dram_link_assertions (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // link signals
   input wire logic sys_clk,
   input wire logic chip_sel_n,
   input wire logic write_cmd_n,
   input wire logic refresh_cmd_n,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [`BANK_W-1:0] bank,
   input wire logic write_data_clk,
   input wire logic [`DATA_W-1:0] write_data_in,
   input wire logic write_mask,
   input wire logic [1:0] read_data_clk,
   input wire logic [`DATA_W-1:0] read_data_out,
   input wire logic read_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] vld_run_reg;
   wire [`ADDR_W+5:0] cmd_bus = {chip_sel_n, write_cmd_n, refresh_cmd_n, addr, bank};
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) vld_run_reg <= 6'h00;
      else if (read_valid) vld_run_reg <= vld_run_reg + 6'h01;
      else vld_run_reg <= 6'h00;
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   a_cmd_off_rise: assert property ($changed(cmd_bus) |-> !sys_clk)
      else $error("command bus changed while link clock high");
   a_cmd_one_period: assert property ($fell(chip_sel_n) |-> !chip_sel_n[*8])
      else $error("command not held one link period");
   a_link_clk_half: assert property ($rose(sys_clk) |-> sys_clk[*4] ##1 !sys_clk)
      else $error("link clock half period wrong");
   a_dclk_phase: assert property (write_data_clk == sys_clk)
      else $error("write data clock out of phase");
   a_wdata_mid: assert property (
      $changed({write_data_in, write_mask}) |-> $stable(write_data_clk))
      else $error("write data changed on its clock edge");
   a_qclk_pair: assert property (read_data_clk[0] == read_data_clk[1])
      else $error("output clock pairs differ");
   a_qclk_free: assert property (
      $rose(read_data_clk[0]) |-> read_data_clk[0][*4] ##1 !read_data_clk[0])
      else $error("output clock not running");
   a_qdata_edge: assert property ($changed(read_data_out) |-> $changed(read_data_clk[0]))
      else $error("read data not edge aligned");
   a_valid_edge: assert property ($changed(read_valid) |-> $changed(read_data_clk[0]))
      else $error("read valid not edge aligned");
   a_valid_len: assert property (vld_run_reg <= 6'h20)
      else $error("read valid longer than eight beats");
   cover property ($fell(chip_sel_n) && !write_cmd_n && refresh_cmd_n);
   cover property ($fell(chip_sel_n) && write_cmd_n && !refresh_cmd_n);
   cover property ($fell(chip_sel_n) && !write_cmd_n && !refresh_cmd_n);
   cover property ($rose(read_valid));
endmodule

/* test/tb_low_latency_dram_sio_interface.sv */
`include "dram_link_consts.svh"

module tb_low_latency_dram_sio_interface;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clock;
   logic i_rst_n;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [17:0] mode_word;
   logic [12:0] ref_row;
   logic [2:0] ref_bank;
   logic [2:0] last_bank = 3'h0;
   logic [33:0] exp_q[$];
   int n_ref = 0;
   int n_errors = 0;
   int n_tests = 0;

   dram_link_if u_dram_link_if ();
   dram_link_ctrl u_dram_link_ctrl (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(u_dram_link_if.ctrl));
   dram_link_mem u_dram_link_mem (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .link(u_dram_link_if.mem), .o_mode_word(mode_word), .o_refresh_row(ref_row),
      .o_refresh_bank(ref_bank));
   dram_link_assertions chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .sys_clk(u_dram_link_if.sys_clk), .chip_sel_n(u_dram_link_if.chip_sel_n),
      .write_cmd_n(u_dram_link_if.write_cmd_n), .refresh_cmd_n(u_dram_link_if.refresh_cmd_n),
      .addr(u_dram_link_if.addr), .bank(u_dram_link_if.bank),
      .write_data_clk(u_dram_link_if.write_data_clk),
      .write_data_in(u_dram_link_if.write_data_in), .write_mask(u_dram_link_if.write_mask),
      .read_data_clk(u_dram_link_if.read_data_clk),
      .read_data_out(u_dram_link_if.read_data_out), .read_valid(u_dram_link_if.read_valid));

   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      n_tests++;
      if (seen !== want) begin
         n_errors++;
         $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic conclude();
      if (n_errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge i_clock);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         n_errors++;
         conclude();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // every read notes its expectation; chk low means the value is not judged
   task automatic rd_exp(input logic [7:0] a, input logic chk, input logic [32:0] want);
      exp_q.push_back({chk, want});
      apb(1'b0, a, 32'h0);
   endtask

   task automatic wait_idle();
      int k;
      for (k = 0; k < 100; k++) begin
         rd_exp(`REG_STATUS, 1'b0, 33'h0);
         if (rd[0] === 1'b0) break;
      end
      if (k == 100) begin
         n_errors++;
         conclude();
      end
   endtask

   task automatic cmd(input logic [1:0] op, input logic [2:0] b, input logic [20:0] a);
      apb(1'b1, `REG_ADDR, {11'h0, a});
      apb(1'b1, `REG_CMD, {27'h0, b, op});
      wait_idle();
   endtask

   task automatic wr_burst(input int bl, input logic [2:0] b, input logic [20:0] a,
         input logic [17:0] base, input logic [7:0] mask);
      for (int i = 0; i < bl; i++) begin
         apb(1'b1, `REG_WBUF + 8'(4 * i), {13'h0, mask[i], base + 18'(i)});
      end
      cmd(dram_link_pkg::CMD_WRITE, b, a);
   endtask

   // completed reads are judged in order against the oldest note
   always @(posedge i_clock) begin
      logic [33:0] e;
      if (psel && penable && pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e[33]) check({pslverr, prdata}, e[32:0]);
      end
      if (i_rst_n === 1'b1 && ref_bank !== last_bank) begin
         n_ref++;
         check({30'h0, ref_bank}, {30'h0, last_bank + 3'h1});
         check({20'h0, ref_row}, {20'h0, 13'(n_ref / 8)});
         last_bank <= ref_bank;
      end
   end

   initial begin
      logic [17:0] d0, d1, d2, mw;
      logic [20:0] a, drop;
      logic [2:0] b;
      int bl;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      i_rst_n = 1'b0;
      void'($urandom(32'h6a8c6309));
      repeat (10) @(posedge i_clock);
      i_rst_n <= 1'b1;
      @(posedge i_clock);
      check({15'h0, mode_word}, {15'h0, `MODE_RST});
      rd_exp(8'h10, 1'b1, {1'b1, 32'h0});
      for (int c = 0; c < 3; c++) begin
         bl = 2 << c;
         mw = 18'((c << 3) | (c + 1));
         apb(1'b1, `REG_CFG, 32'h1);
         cmd(dram_link_pkg::CMD_MODE, 3'h0, {3'h0, mw});
         check({15'h0, mode_word}, {15'h0, mw});
         a = 21'($urandom);
         b = 3'($urandom);
         d0 = 18'($urandom);
         d1 = 18'($urandom);
         d2 = 18'($urandom);
         drop = (c == 0) ? 21'h100000 : ((c == 1) ? 21'h180000 : 21'h1c0000);
         wr_burst(bl, b, a, d0, 8'h00);
         wr_burst(bl, b ^ 3'h1, a, d1, 8'h00);
         wr_burst(bl, b, a ^ drop, d2, 8'h02);
         // auto refresh off so that no refresh sets busy during the read-back
         apb(1'b1, `REG_CFG, 32'h0);
         cmd(dram_link_pkg::CMD_READ, b, a);
         for (int i = 0; i < bl; i++) begin
            rd_exp(`REG_RBUF + 8'(4 * i), 1'b1, {15'h0, ((i == 1) ? d0 : d2) + 18'(i)});
         end
         rd_exp(`REG_STATUS, 1'b1, {25'h0, 4'(bl), 4'h0});
         rd_exp(`REG_CFG, 1'b1, 33'h0);
         rd_exp(`REG_ADDR, 1'b1, {12'h0, a});
         rd_exp(`REG_CMD, 1'b1, {28'h0, b, 2'b11});
      end
      cmd(dram_link_pkg::CMD_MODE, 3'h0, 21'h00019);
      check({15'h0, mode_word}, {15'h0, mw});
      conclude();
   end
endmodule

/* verilog/dram_link_consts.svh */
`ifndef DRAM_LINK_CONSTS_SVH
`define DRAM_LINK_CONSTS_SVH

// clocking
`define CLK_PERIOD_NS 10
`define LINK_PERIOD_NS 80
`define LINK_CYC (`LINK_PERIOD_NS / `CLK_PERIOD_NS)
`define LINK_HALF (`LINK_CYC / 2)
`define PH_PRE_RISE (`LINK_CYC - 1)
`define PH_PRE_FALL (`LINK_HALF - 1)
`define PH_PRE_DFALL (`LINK_HALF / 2 - 1)
`define PH_PRE_DRISE (`LINK_HALF + `LINK_HALF / 2 - 1)
`define MRSC_CK 6

// refresh: every bank 8K times, 64k commands per 32 ms
`define REF_WINDOW_NS 32000000
`define REF_CMDS 65536
`define REF_GAP_CYC (`REF_WINDOW_NS / `REF_CMDS / `CLK_PERIOD_NS)

// link widths
`define ADDR_W 21
`define BANK_W 3
`define DATA_W 18
`define MODE_W 18
`define ROW_W 13
`define MEM_OFS_W 5
`define BL_MAX 8

// mode word fields and reset value
`define MODE_RL_LSB 0
`define MODE_BL_LSB 3
`define MODE_RST 18'h00001

// address bits in use per burst length
`define AMASK_BL2 21'h0fffff
`define AMASK_BL4 21'h07ffff
`define AMASK_BL8 21'h03ffff

// controller register offsets
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_CFG 8'h08
`define REG_STATUS 8'h0c
`define REG_WBUF 8'h20
`define REG_RBUF 8'h40
`define CFG_RST 1'h1

`endif

/* verilog/dram_link_ctrl.sv */
`include "dram_link_consts.svh"

module dram_link_ctrl (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // memory link
   dram_link_if.ctrl link
);
   logic [2:0] phase_reg;
   logic ck_reg, dk_reg, cs_n_reg, we_n_reg, ref_n_reg, wmask_reg;
   logic [`ADDR_W-1:0] aout_reg, addr_reg;
   logic [`BANK_W-1:0] bout_reg, bank_reg, ref_bank_reg;
   logic [`DATA_W-1:0] wdata_reg;
   logic [1:0] op_reg;
   logic go_reg, ref_en_reg, ref_due_reg;
   logic [`DATA_W:0] wbuf [0:`BL_MAX-1];
   logic [`DATA_W-1:0] rbuf [0:`BL_MAX-1];
   dram_link_pkg::ctl_state_t state_reg;
   dram_link_pkg::cmd_t cur_reg;
   logic [4:0] ccount_reg;
   logic [3:0] rcount_reg;
   logic [1:0] bl_code_reg;
   logic [2:0] rl_reg;
   logic [5:0] ref_timer_reg;
   logic [`DATA_W+1:0] rx_s1_reg, rx_s2_reg;
   logic qk_s3_reg;

   // link-side read pins pass two flops
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_s1_reg <= '0;
         rx_s2_reg <= '0;
         qk_s3_reg <= 1'b0;
      end else begin
         rx_s1_reg <= {link.read_data_clk[0], link.read_valid, link.read_data_out};
         rx_s2_reg <= rx_s1_reg;
         qk_s3_reg <= rx_s2_reg[`DATA_W+1];
      end
   end

   wire qk_edge = rx_s2_reg[`DATA_W+1] ^ qk_s3_reg;
   wire rvalid_s = rx_s2_reg[`DATA_W];
   wire [3:0] bl_words = (bl_code_reg == 2'b10) ? 4'h8 : (bl_code_reg == 2'b01) ? 4'h4 : 4'h2;
   wire [2:0] rl_eff = (rl_reg == 3'h0) ? 3'h1 : rl_reg;
   wire busy = go_reg | (state_reg == dram_link_pkg::ST_BUSY);
   wire launch = (phase_reg == 3'(`PH_PRE_RISE - `LINK_HALF)) &&
      (state_reg == dram_link_pkg::ST_IDLE) && (ref_due_reg || go_reg);
   wire [4:0] ccount_next = ccount_reg + 5'h1;
   wire ph_dfall = (phase_reg == 3'(`PH_PRE_DFALL));
   wire ph_drise = (phase_reg == 3'(`PH_PRE_DRISE));
   wire [5:0] wbeat = {ccount_reg, 1'b0} - {2'b00, rl_eff, 1'b0} - {5'h00, ph_dfall};
   wire wbeat_ok = wbeat < {2'b00, bl_words};
   wire ref_tick = ref_timer_reg == 6'(`REF_GAP_CYC - 1);

   // apb decode
   wire setup = i_psel & ~i_penable;
   wire wr_en = i_psel & i_penable & o_pready & i_pwrite;
   wire hit_wbuf = (i_paddr[7:5] == 3'(`REG_WBUF >> 5)) & (i_paddr[1:0] == 2'b00);
   wire hit_rbuf = (i_paddr[7:5] == 3'(`REG_RBUF >> 5)) & (i_paddr[1:0] == 2'b00);
   wire hit = (i_paddr == `REG_CMD) | (i_paddr == `REG_ADDR) | (i_paddr == `REG_CFG) |
      (i_paddr == `REG_STATUS) | hit_wbuf | hit_rbuf;
   wire [31:0] rd_word =
      (i_paddr == `REG_CMD) ? {27'h0, bank_reg, op_reg} :
      (i_paddr == `REG_ADDR) ? {11'h0, addr_reg} :
      (i_paddr == `REG_CFG) ? {31'h0, ref_en_reg} :
      (i_paddr == `REG_STATUS) ? {24'h0, rcount_reg, 3'h0, busy} :
      hit_wbuf ? {13'h0, wbuf[i_paddr[4:2]]} :
      hit_rbuf ? {14'h0, rbuf[i_paddr[4:2]]} : 32'h0;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= setup;
         o_pslverr <= setup & ~hit;
         if (setup) begin
            o_prdata <= rd_word;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (wr_en && hit_wbuf) begin
         wbuf[i_paddr[4:2]] <= i_pwdata[`DATA_W:0];
      end
      if (qk_edge && rvalid_s && state_reg == dram_link_pkg::ST_BUSY &&
          cur_reg == dram_link_pkg::CMD_READ && rcount_reg < bl_words) begin
         rbuf[rcount_reg[2:0]] <= rx_s2_reg[`DATA_W-1:0];
      end
   end

   // software registers and refresh scheduling
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         op_reg <= 2'h0;
         bank_reg <= '0;
         addr_reg <= '0;
         go_reg <= 1'b0;
         ref_en_reg <= `CFG_RST;
         ref_timer_reg <= 6'h0;
         ref_due_reg <= 1'b0;
         ref_bank_reg <= '0;
      end else begin
         if (wr_en && i_paddr == `REG_CMD && !busy) begin
            op_reg <= i_pwdata[1:0];
            bank_reg <= i_pwdata[4:2];
            go_reg <= 1'b1;
         end else if (launch && !ref_due_reg) begin
            go_reg <= 1'b0;
         end
         if (wr_en && i_paddr == `REG_ADDR) begin
            addr_reg <= i_pwdata[`ADDR_W-1:0];
         end
         if (wr_en && i_paddr == `REG_CFG) begin
            ref_en_reg <= i_pwdata[0];
         end
         ref_timer_reg <= ref_tick ? 6'h0 : ref_timer_reg + 6'h1;
         if (ref_tick && ref_en_reg) begin
            ref_due_reg <= 1'b1;
         end else if (launch && ref_due_reg) begin
            ref_due_reg <= 1'b0;
         end
         // the bank advances on every issued refresh, even when a new one is due
         if (launch && ref_due_reg) begin
            ref_bank_reg <= ref_bank_reg + 3'h1;
         end
      end
   end

   // link clock divider, command slot and write beats
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase_reg <= 3'h0;
         ck_reg <= 1'b1;
         dk_reg <= 1'b1;
         cs_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         ref_n_reg <= 1'b1;
         aout_reg <= '0;
         bout_reg <= '0;
         wdata_reg <= '0;
         wmask_reg <= 1'b1;
         state_reg <= dram_link_pkg::ST_IDLE;
         cur_reg <= dram_link_pkg::CMD_REFRESH;
         ccount_reg <= 5'h0;
         rcount_reg <= 4'h0;
         bl_code_reg <= 2'(`MODE_RST >> `MODE_BL_LSB);
         rl_reg <= 3'(`MODE_RST >> `MODE_RL_LSB);
      end else begin
         phase_reg <= phase_reg + 3'h1;
         if (phase_reg == 3'(`PH_PRE_RISE)) begin
            ck_reg <= 1'b1;
            dk_reg <= 1'b1;
         end else if (phase_reg == 3'(`PH_PRE_FALL)) begin
            ck_reg <= 1'b0;
            dk_reg <= 1'b0;
         end
         // commands change at the falling edge, stable at the rising one
         if (phase_reg == 3'(`PH_PRE_FALL)) begin
            cs_n_reg <= ~launch;
            if (launch) begin
               cur_reg <= ref_due_reg ? dram_link_pkg::CMD_REFRESH : dram_link_pkg::cmd_t'(op_reg);
               {we_n_reg, ref_n_reg} <= ref_due_reg ? 2'b10 : op_reg;
               bout_reg <= ref_due_reg ? ref_bank_reg : bank_reg;
               aout_reg <= addr_reg;
               state_reg <= dram_link_pkg::ST_BUSY;
               ccount_reg <= 5'h0;
               // only a new read clears the captured count, refreshes keep it
               if (!ref_due_reg && op_reg == 2'b11) begin
                  rcount_reg <= 4'h0;
               end
               if (!ref_due_reg && op_reg == 2'b00 && addr_reg[`MODE_BL_LSB +: 2] != 2'b11) begin
                  bl_code_reg <= addr_reg[`MODE_BL_LSB +: 2];
                  rl_reg <= addr_reg[`MODE_RL_LSB +: 3];
               end
            end
         end
         if ((ph_dfall || ph_drise) && state_reg == dram_link_pkg::ST_BUSY &&
             cur_reg == dram_link_pkg::CMD_WRITE && wbeat_ok) begin
            wdata_reg <= wbuf[wbeat[2:0]][`DATA_W-1:0];
            wmask_reg <= wbuf[wbeat[2:0]][`DATA_W];
         end else if (ph_dfall || ph_drise) begin
            wdata_reg <= '0;
            wmask_reg <= 1'b1;
         end
         if (qk_edge && rvalid_s && state_reg == dram_link_pkg::ST_BUSY &&
             cur_reg == dram_link_pkg::CMD_READ && rcount_reg < bl_words) begin
            rcount_reg <= rcount_reg + 4'h1;
         end
         if (state_reg == dram_link_pkg::ST_BUSY) begin
            if (phase_reg == 3'(`PH_PRE_RISE)) begin
               ccount_reg <= ccount_next;
               if ((cur_reg == dram_link_pkg::CMD_MODE && ccount_next == 5'(`MRSC_CK)) ||
                   (cur_reg == dram_link_pkg::CMD_REFRESH && ccount_next == 5'h1) ||
                   (cur_reg == dram_link_pkg::CMD_WRITE &&
                    ccount_next == {2'b00, rl_eff} + {2'b00, bl_words[3:1]} + 5'h1)) begin
                  state_reg <= dram_link_pkg::ST_IDLE;
               end
            end
            if (cur_reg == dram_link_pkg::CMD_READ && rcount_reg == bl_words) begin
               state_reg <= dram_link_pkg::ST_IDLE;
            end
         end
      end
   end

   assign link.sys_clk = ck_reg;
   assign link.write_data_clk = dk_reg;
   assign link.chip_sel_n = cs_n_reg;
   assign link.write_cmd_n = we_n_reg;
   assign link.refresh_cmd_n = ref_n_reg;
   assign link.addr = aout_reg;
   assign link.bank = bout_reg;
   assign link.write_data_in = wdata_reg;
   assign link.write_mask = wmask_reg;
endmodule

/* verilog/dram_link_if.sv */
`include "dram_link_consts.svh"

interface dram_link_if;
   logic sys_clk;
   logic chip_sel_n;
   logic write_cmd_n;
   logic refresh_cmd_n;
   logic [`ADDR_W-1:0] addr;
   logic [`BANK_W-1:0] bank;
   logic write_data_clk;
   logic [`DATA_W-1:0] write_data_in;
   logic write_mask;
   logic [1:0] read_data_clk;
   logic [`DATA_W-1:0] read_data_out;
   logic read_valid;

   modport ctrl (
      output sys_clk, chip_sel_n, write_cmd_n, refresh_cmd_n, addr, bank,
      output write_data_clk, write_data_in, write_mask,
      input read_data_clk, read_data_out, read_valid
   );

   modport mem (
      input sys_clk, chip_sel_n, write_cmd_n, refresh_cmd_n, addr, bank,
      input write_data_clk, write_data_in, write_mask,
      output read_data_clk, read_data_out, read_valid
   );
endinterface

/* verilog/dram_link_mem.sv */
`include "dram_link_consts.svh"

// Notes on behaviour
// - commands and address taken at system clock rise
// - chip select high ignores commands, work continues
// - write and refresh inputs pick the command
// - burst length programmed as 2, 4 or 8
// - burst eight drops A18, A19; four drops A19
// - address bit 20 has no effect
// - three bank bits pick one of eight banks
// - write data taken on both data clock edges
// - words taken with mask high are not written
// - read data leaves on both output clock edges
// - clock pair 0 for bits 0-8, 1 for 9-17
// - read valid marks read data, clock aligned
// - two data words per clock cycle
// - separate read and write data pins
// - output data clocks run all the time
// - controller refreshes 64k times per 32 ms
// - refresh per bank, row counted internally
// - latency and burst length are programmable, balanced
// - mode set takes its word from address
// - built as 18-bit words, separate buses
// - deselect, mode, read, write, refresh encodings
// - mode set only when all banks idle
// - address width 19:0, 18:0, 17:0 per burst
module dram_link_mem (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // link to the controller
   dram_link_if.mem link,
   // device status
   output logic [`MODE_W-1:0] o_mode_word,
   output logic [`ROW_W-1:0] o_refresh_row,
   output logic [`BANK_W-1:0] o_refresh_bank
);
   localparam int SYNC_W = 5 + `BANK_W + `ADDR_W + `DATA_W + 1;

   logic [SYNC_W-1:0] pin_raw, pin_s1_reg, pin_s2_reg;
   logic ck_s3_reg, dk_s3_reg;
   logic ck_s, dk_s, cs_n_s, we_n_s, ref_n_s, wmask_s;
   logic [`BANK_W-1:0] bank_s;
   logic [`ADDR_W-1:0] addr_s;
   logic [`DATA_W-1:0] wdata_s;
   logic [`MODE_W-1:0] mode_reg;
   logic [`DATA_W-1:0] mem [0:(1 << (`BANK_W + `MEM_OFS_W)) - 1];
   logic [`ROW_W-1:0] row_reg [0:(1 << `BANK_W) - 1];
   logic wr_act_reg, rd_act_reg;
   logic [4:0] wr_cnt_reg, rd_cnt_reg;
   logic [`BANK_W-1:0] wr_bank_reg, rd_bank_reg;
   logic [`MEM_OFS_W-1:0] wr_ofs_reg, rd_ofs_reg;
   logic [1:0] qk_div_reg;
   logic [1:0] qk_reg;
   logic [`DATA_W-1:0] rdata_reg;
   logic rvalid_reg;

   // every link pin passes two flops before use
   assign pin_raw = {link.sys_clk, link.write_data_clk, link.chip_sel_n, link.write_cmd_n,
      link.refresh_cmd_n, link.bank, link.addr, link.write_data_in, link.write_mask};

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_s1_reg <= '1;
         pin_s2_reg <= '1;
         ck_s3_reg <= 1'b1;
         dk_s3_reg <= 1'b1;
      end else begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         ck_s3_reg <= ck_s;
         dk_s3_reg <= dk_s;
      end
   end

   assign {ck_s, dk_s, cs_n_s, we_n_s, ref_n_s, bank_s, addr_s, wdata_s, wmask_s} = pin_s2_reg;

   // command decode
   wire ck_rise = ck_s & ~ck_s3_reg;
   wire dk_edge = dk_s ^ dk_s3_reg;
   wire cmd_ok = ck_rise & ~cs_n_s;
   wire dram_link_pkg::cmd_t cmd = dram_link_pkg::cmd_t'({we_n_s, ref_n_s});
   wire is_mode = cmd_ok && cmd == dram_link_pkg::CMD_MODE;
   wire is_write = cmd_ok && cmd == dram_link_pkg::CMD_WRITE;
   wire is_read = cmd_ok && cmd == dram_link_pkg::CMD_READ;
   wire is_ref = cmd_ok && cmd == dram_link_pkg::CMD_REFRESH;

   // mode word fields
   wire dram_link_pkg::bl_t bl_code = dram_link_pkg::bl_t'(mode_reg[`MODE_BL_LSB +: 2]);
   wire [2:0] rl_field = mode_reg[`MODE_RL_LSB +: 3];
   wire [2:0] rl_eff = (rl_field == 3'h0) ? 3'h1 : rl_field;
   wire [4:0] lat2 = {1'b0, rl_eff, 1'b0};
   wire [4:0] bl_words = (bl_code == dram_link_pkg::BL8) ? 5'h08 :
      (bl_code == dram_link_pkg::BL4) ? 5'h04 : 5'h02;
   wire [1:0] bl_shift = (bl_code == dram_link_pkg::BL8) ? 2'h3 :
      (bl_code == dram_link_pkg::BL4) ? 2'h2 : 2'h1;
   wire [`ADDR_W-1:0] amask = (bl_code == dram_link_pkg::BL8) ? `AMASK_BL8 :
      (bl_code == dram_link_pkg::BL4) ? `AMASK_BL4 : `AMASK_BL2;
   wire [`ADDR_W-1:0] addr_used = addr_s & amask;
   wire [`MEM_OFS_W-1:0] ofs_base = addr_used[`MEM_OFS_W-1:0] << bl_shift;
   wire mode_legal = addr_s[`MODE_BL_LSB +: 2] != 2'b11;

   // write beats counted in data clock edges from the command
   wire [4:0] wr_cnt_next = wr_cnt_reg + 5'h1;
   wire [4:0] wr_beat = wr_cnt_next - lat2;
   wire wr_win = wr_act_reg && wr_cnt_next >= lat2 && wr_beat < bl_words;
   wire wr_store = dk_edge && !is_write && wr_win && !wmask_s;
   wire [`BANK_W+`MEM_OFS_W-1:0] wr_idx = {wr_bank_reg, wr_ofs_reg + wr_beat};

   // output data clock and read beats counted in its edges
   wire qk_tick = qk_div_reg == 2'(`LINK_HALF - 1);
   wire [4:0] rd_cnt_next = rd_cnt_reg + 5'h1;
   wire [4:0] rd_beat = rd_cnt_next - lat2;
   wire rd_win = rd_act_reg && rd_cnt_next >= lat2 && rd_beat < bl_words;
   wire [`BANK_W+`MEM_OFS_W-1:0] rd_idx = {rd_bank_reg, rd_ofs_reg + rd_beat};

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_reg <= `MODE_RST;
      end else if (is_mode && mode_legal) begin
         mode_reg <= addr_s[`MODE_W-1:0];
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_act_reg <= 1'b0;
         wr_cnt_reg <= 5'h0;
         wr_bank_reg <= '0;
         wr_ofs_reg <= '0;
      end else if (is_write) begin
         wr_act_reg <= 1'b1;
         wr_cnt_reg <= 5'h0;
         wr_bank_reg <= bank_s;
         wr_ofs_reg <= ofs_base;
      end else if (dk_edge && wr_act_reg) begin
         wr_cnt_reg <= wr_cnt_next;
         if (wr_win && wr_beat == bl_words - 5'h1) begin
            wr_act_reg <= 1'b0;
         end
      end
   end

   // dedicated input and output data paths, no turnaround
   always_ff @(posedge i_clock) begin
      if (wr_store) begin
         mem[wr_idx] <= wdata_s;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         qk_div_reg <= 2'h0;
         qk_reg <= 2'b00;
      end else begin
         qk_div_reg <= qk_div_reg + 2'h1;
         if (qk_tick) begin
            qk_reg <= ~qk_reg;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_act_reg <= 1'b0;
         rd_cnt_reg <= 5'h0;
         rd_bank_reg <= '0;
         rd_ofs_reg <= '0;
         rdata_reg <= '0;
         rvalid_reg <= 1'b0;
      end else begin
         if (is_read) begin
            rd_act_reg <= 1'b1;
            rd_cnt_reg <= 5'h0;
            rd_bank_reg <= bank_s;
            rd_ofs_reg <= ofs_base;
         end else if (qk_tick && rd_act_reg) begin
            rd_cnt_reg <= rd_cnt_next;
            if (rd_win && rd_beat == bl_words - 5'h1) begin
               rd_act_reg <= 1'b0;
            end
         end
         // data and valid change together with the clock toggle
         if (qk_tick) begin
            rvalid_reg <= rd_win && !is_read;
            if (rd_win && !is_read) begin
               rdata_reg <= mem[rd_idx];
            end
         end
      end
   end

   // per-bank refresh row counters
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < (1 << `BANK_W); i++) begin
            row_reg[i] <= '0;
         end
         o_refresh_row <= '0;
         o_refresh_bank <= '0;
      end else if (is_ref) begin
         row_reg[bank_s] <= row_reg[bank_s] + `ROW_W'(1);
         o_refresh_row <= row_reg[bank_s];
         o_refresh_bank <= bank_s;
      end
   end

   assign o_mode_word = mode_reg;
   assign link.read_data_clk = qk_reg;
   assign link.read_data_out = rdata_reg;
   assign link.read_valid = rvalid_reg;
endmodule

/* verilog/dram_link_pkg.sv */
package dram_link_pkg;
   // command code is {write_cmd_n, refresh_cmd_n}
   typedef enum logic [1:0] {
      CMD_MODE = 2'b00,
      CMD_WRITE = 2'b01,
      CMD_REFRESH = 2'b10,
      CMD_READ = 2'b11
   } cmd_t;

   typedef enum logic [1:0] {
      BL2 = 2'b00,
      BL4 = 2'b01,
      BL8 = 2'b10
   } bl_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } ctl_state_t;
endpackage
